// *** hw/hrc_range_compare.sv ***
`timescale 1ns/100ps
`include "hrc_map.svh"
module hrc_range_compare (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              op_start,
    input  wire hrc_pkg::hrc_pulse_s [3:0] pulse_in,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic [31:0]            wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   irq_req,
    output logic [7:0]             irq_task
);
    hrc_pkg::hrc_state_s s_r;
    hrc_pkg::hrc_state_s s_nxt;

    logic       wr;
    logic [7:0] in_now;
    logic [7:0] adr;
    logic       refresh;
    logic       eval;
    logic       ld_cmd;
    logic [31:0] cmp_cnt;

    assign adr = wb_adr_i;
    assign wr  = wb_cyc_i & wb_stb_i & wb_we_i & ~s_r.ack & (&wb_sel_i);
    assign ld_cmd = wr && (adr == `HRC_CMD);
    // A load or reset command is compared with the value being written, so the flags
    // evaluated by that command already describe the new count.
    assign cmp_cnt = (ld_cmd && wb_dat_i[`HRC_CMD_RESET]) ? 32'h0000_0000
                   : (ld_cmd && wb_dat_i[`HRC_CMD_SETPV]) ? s_r.pv_set : s_r.cnt[0];

    // Each range is compared against cmp_cnt: the live counter 0 value, or the value a load or reset command sets.
    generate
        for (genvar g = 0; g < 8; g++) begin : g_rng
            logic [31:0] lo;
            logic [31:0] hi;
            logic        dis;
            assign lo  = {s_r.tbl[g*5+1], s_r.tbl[g*5]};
            assign hi  = {s_r.tbl[g*5+3], s_r.tbl[g*5+2]};
            assign dis = (s_r.tbl[g*5+4] == `HRC_RANGE_OFF);
            assign in_now[g] = ~dis && (cmp_cnt >= lo) && (cmp_cnt <= hi);
        end
    endgenerate

    always_comb begin
        int          i;
        logic [7:0]  cmd;
        i     = 0;
        s_nxt = s_r;
        cmd   = 8'h00;
        s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
        if (wr && adr == `HRC_CMD) begin
            cmd = wb_dat_i[7:0];
        end
        for (i = 0; i < 4; i++) begin
            if (pulse_in[i].up && !pulse_in[i].down) begin
                if (s_r.ctrl[`HRC_CTRL_RING] && s_r.cnt[i] >= s_r.ring_max) begin
                    s_nxt.cnt[i] = 32'h0000_0000;
                end else begin
                    s_nxt.cnt[i] = s_r.cnt[i] + 32'h0000_0001;
                end
            end else if (pulse_in[i].down && !pulse_in[i].up) begin
                if (s_r.ctrl[`HRC_CTRL_RING] && s_r.cnt[i] == 32'h0000_0000) begin
                    s_nxt.cnt[i] = s_r.ring_max;
                end else begin
                    s_nxt.cnt[i] = s_r.cnt[i] - 32'h0000_0001;
                end
            end
        end
        if (cmd[`HRC_CMD_SETPV]) begin
            s_nxt.cnt[0] = s_r.pv_set;
        end
        if (cmd[`HRC_CMD_RESET]) begin
            s_nxt.cnt[0] = 32'h0000_0000;
        end
        if (cmd[`HRC_CMD_SETMAX]) begin
            s_nxt.ring_max = s_r.pv_set;
        end
        // Scan period divider gives the per-scan refresh enable.
        if (s_r.scan_cnt >= s_r.scan_len) begin
            s_nxt.scan_cnt = 32'h0000_0000;
        end else begin
            s_nxt.scan_cnt = s_r.scan_cnt + 32'h0000_0001;
        end
        refresh = (s_r.scan_cnt >= s_r.scan_len) | cmd[`HRC_CMD_READ] | cmd[`HRC_CMD_CONV]
                | cmd[`HRC_CMD_SETPV] | cmd[`HRC_CMD_SETMAX];
        eval = refresh | cmd[`HRC_CMD_RESET];
        if (refresh) begin
            s_nxt.pv = s_nxt.cnt;
        end
        if (eval) begin
            s_nxt.inr = in_now;
        end
        // Entry detection uses the live compare so a short visit is still caught.
        s_nxt.prev = in_now;
        if (s_r.irq_st == hrc_pkg::HRC_IDLE && s_r.ctrl[`HRC_CTRL_CMP]) begin
            for (i = 7; i >= 0; i--) begin
                if (in_now[i] && !s_r.prev[i] && s_r.tbl[i*5+4][`HRC_ENTER_BIT]
                    && s_r.tbl[i*5+4] != `HRC_TASK_OFF) begin
                    s_nxt.irq_st   = hrc_pkg::HRC_BUSY;
                    s_nxt.irq_task = s_r.tbl[i*5+4][7:0];
                end
            end
        end
        if (s_r.irq_st == hrc_pkg::HRC_BUSY && cmd[`HRC_CMD_ACK]) begin
            s_nxt.irq_st = hrc_pkg::HRC_IDLE;
        end
        if (wr) begin
            if (adr < `HRC_TABLE_WORDS) begin
                s_nxt.tbl[adr[5:0]] = wb_dat_i[15:0];
            end else if (adr == `HRC_CTRL) begin
                s_nxt.ctrl = wb_dat_i[1:0];
            end else if (adr == `HRC_PV_SET) begin
                s_nxt.pv_set = wb_dat_i;
            end else if (adr == `HRC_RING_MAX) begin
                s_nxt.ring_max = wb_dat_i;
            end else if (adr == `HRC_SCAN) begin
                s_nxt.scan_len = wb_dat_i;
            end
        end
        if (op_start || cmd[`HRC_CMD_START]) begin
            s_nxt.pv  = '0;
            s_nxt.inr = 8'h00;
        end
        s_nxt.rdat = 32'h0000_0000;
        // two halves, flags at bit 0
        if (adr < `HRC_TABLE_WORDS) begin
            s_nxt.rdat = {16'h0000, s_r.tbl[adr[5:0]]};
        end else if (adr >= `HRC_PV_BASE && adr < `HRC_STATUS0) begin
            s_nxt.rdat = adr[0] ? {16'h0000, s_r.pv[adr[2:1]][31:16]}
                                : {16'h0000, s_r.pv[adr[2:1]][15:0]};
        end else if (adr == `HRC_STATUS0) begin
            s_nxt.rdat = {23'h000000, s_r.ctrl[`HRC_CTRL_CMP], s_r.inr};
        end else if (adr == `HRC_CTRL) begin
            s_nxt.rdat = {30'h00000000, s_r.ctrl};
        end else if (adr == `HRC_IRQ_INFO) begin
            s_nxt.rdat = {23'h000000, s_r.irq_st == hrc_pkg::HRC_BUSY, s_r.irq_task};
        end else if (adr == `HRC_RING_MAX) begin
            s_nxt.rdat = s_r.ring_max;
        end else if (adr == `HRC_PV_SET) begin
            s_nxt.rdat = s_r.pv_set;
        end else if (adr == `HRC_SCAN) begin
            s_nxt.rdat = s_r.scan_len;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_r          <= '0;
            s_r.scan_len <= `HRC_SCAN_DEF;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdat;
    assign irq_req  = (s_r.irq_st == hrc_pkg::HRC_BUSY);
    assign irq_task = s_r.irq_task;
endmodule

// *** hw/hrc_map.svh ***
`ifndef HRC_MAP_SVH
`define HRC_MAP_SVH
`define HRC_TABLE_BASE    8'h00
`define HRC_TABLE_WORDS   8'h28
`define HRC_PV_BASE       8'h40
`define HRC_STATUS0       8'h48
`define HRC_CTRL          8'h49
`define HRC_CMD           8'h4A
`define HRC_IRQ_INFO      8'h4B
`define HRC_RING_MAX      8'h4C
`define HRC_PV_SET        8'h4D
`define HRC_SCAN          8'h4E
`define HRC_TASK_OFF      16'hAAAA
`define HRC_RANGE_OFF     16'hFFFF
`define HRC_ENTER_BIT     15
`define HRC_CTRL_CMP      0
`define HRC_CTRL_RING     1
`define HRC_CMD_START     0
`define HRC_CMD_READ      1
`define HRC_CMD_CONV      2
`define HRC_CMD_SETPV     3
`define HRC_CMD_SETMAX    4
`define HRC_CMD_RESET     5
`define HRC_CMD_ACK       6
`define HRC_SCAN_DEF      32'h0000_C350
`endif

// *** hw/hrc_pkg.sv ***
package hrc_pkg;
    typedef struct packed {
        logic        up;
        logic        down;
    } hrc_pulse_s;
    typedef enum logic [0:0] {
        HRC_IDLE = 1'b0,
        HRC_BUSY = 1'b1
    } hrc_irq_e;
    typedef struct packed {
        logic [39:0][15:0] tbl;
        logic [3:0][31:0]  cnt;
        logic [3:0][31:0]  pv;
        logic [7:0]        inr;
        logic [7:0]        prev;
        logic [1:0]        ctrl;
        logic [31:0]       ring_max;
        logic [31:0]       pv_set;
        logic [31:0]       scan_len;
        logic [31:0]       scan_cnt;
        hrc_irq_e          irq_st;
        logic [7:0]        irq_task;
        logic [31:0]       rdat;
        logic              ack;
    } hrc_state_s;
endpackage

// *** tb/hrc_range_compare_asserts.sv ***
`timescale 1ns/100ps
module hrc_range_compare_asserts (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_req,
    input wire logic [7:0]  irq_task
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence rd_s(lo, hi);
        req_s ##0 (!wb_we_i && wb_adr_i >= lo && wb_adr_i <= hi);
    endsequence
    ack_resp_a: assert property (req_s |=> wb_ack_o)
        else $error("request left unanswered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    ack_idle_a: assert property (!wb_cyc_i |=> !wb_ack_o)
        else $error("ack without a cycle");
    unmap_zero_a: assert property (rd_s(8'h4F, 8'hFF) |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    status_pad_a: assert property (rd_s(8'h48, 8'h48) |=> wb_dat_o[31:9] == 23'h0)
        else $error("status spare bits set");
    irq_hold_a: assert property (irq_req && !wb_we_i && !$past(wb_we_i) |=> irq_req)
        else $error("request dropped unasked");
    task_stable_a: assert property (irq_req ##1 irq_req |-> $stable(irq_task))
        else $error("task number moved");
    irq_fall_a: assert property ($fell(irq_req) |->
        $past(wb_we_i && wb_adr_i == 8'h4A) || $past(wb_we_i && wb_adr_i == 8'h4A, 2))
        else $error("request cleared without command");
endmodule
bind hrc_range_compare hrc_range_compare_asserts i_chk (.clk_sys, .sys_rst, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_req, .irq_task);

// *** tb/hrc_pulse_src.sv ***
`timescale 1ns/100ps
module hrc_pulse_src (
    input  wire logic [3:0]           up_en,
    input  wire logic [3:0]           dn_en,
    output hrc_pkg::hrc_pulse_s [3:0] pulse_in
);
    // An encoder never steps both ways at once, so up wins a clash.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pulse_in[i].up   = up_en[i];
            pulse_in[i].down = dn_en[i] & ~up_en[i];
        end
    end
endmodule

// *** tb/testbench.sv ***
`timescale 1ns/100ps
`include "hrc_map.svh"
module testbench;
    logic        clk_sys, sys_rst, op_start, cyc, stb, we, ack, irq_req;
    logic [7:0]  adr, irq_task, tk;
    logic [31:0] dat, dat_o, q, seed, lo, v;
    logic [3:0]  up_en, dn_en;
    int          fail_count, n_checks, cyc_n;
    hrc_pkg::hrc_pulse_s [3:0] pulse_in;
    hrc_pulse_src i_src (.up_en, .dn_en, .pulse_in);
    hrc_range_compare i_dut (.clk_sys, .sys_rst, .op_start, .pulse_in, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(dat_o), .wb_ack_o(ack), .irq_req, .irq_task);
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc_n <= cyc_n + 1;
        if (cyc_n == 6000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = dat_o;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    // Ten idle cycles cover a five-cycle scan (scan length 4) plus the flag lag.
    task automatic step(input logic [3:0] u, input logic [3:0] d, input int n);
        @(posedge clk_sys);
        {up_en, dn_en} <= {u, d};
        repeat (n) @(posedge clk_sys);
        {up_en, dn_en} <= 8'h00;
        repeat (10) @(posedge clk_sys);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    function automatic logic [31:0] st(input logic [31:0] c);
        return {23'h0, 1'b1, 6'h0, {2{c >= lo && c <= lo + 32'h5}}};
    endfunction
    function automatic logic [15:0] tw(input int w);
        logic [31:0] l;
        l = (w % 5 > 1) ? ((w < 10) ? lo + 32'h5 : 32'hFFFF_FFFF) : ((w < 10) ? lo : 32'h0);
        if (w % 5 == 4) return (w < 5) ? {8'h80, tk} : (w < 10) ? `HRC_TASK_OFF : `HRC_RANGE_OFF;
        return ((w % 5) % 2 == 1) ? l[31:16] : l[15:0];
    endfunction
    initial begin
        {sys_rst, op_start, cyc, stb, we, adr, dat, up_en, dn_en} = '1;
        {op_start, cyc, stb, we, up_en, dn_en} = '0;
        seed = 32'h0000_0036;
        repeat (8) @(posedge clk_sys);
        sys_rst <= 1'b0;
        wb(1'b1, `HRC_PV_BASE, 32'hFFFF_FFFF);
        for (int a = 64; a <= 72; a++) rdc(a[7:0], 32'h0);
        wb(1'b0, 8'h7F, 32'h0);
        wb(1'b1, `HRC_SCAN, 32'h4);
        seed = xs(seed);
        lo = {26'h0, seed[5:0]} + 32'h8;
        seed = xs(seed);
        tk = seed[7:0];
        for (int w = 0; w < 40; w++) wb(1'b1, w[7:0], {16'h0, tw(w)});
        wb(1'b1, `HRC_CTRL, 32'h1);
        step(4'hF, 4'h0, lo - 1);
        rdc(`HRC_STATUS0, st(lo - 1));
        step(4'h1, 4'h0, 1);
        chk({23'h0, irq_req, irq_task}, {24'h1, tk});
        rdc(`HRC_STATUS0, st(lo));
        for (int n = 0; n < 8; n++) rdc(8'(n + 64), n == 0 ? lo : n % 2 ? 0 : lo - 1);
        step(4'h1, 4'h0, 2);
        wb(1'b1, `HRC_CMD, 32'h40);
        step(4'h1, 4'h0, 1);
        chk({31'h0, irq_req}, 32'h0);
        step(4'h1, 4'h0, 3);
        rdc(`HRC_STATUS0, st(lo + 6));
        step(4'h0, 4'h1, 1);
        chk({31'h0, irq_req}, 32'h1);
        wb(1'b1, `HRC_CMD, 32'h40);
        wb(1'b1, `HRC_SCAN, 32'h0010_0000);
        seed = xs(seed);
        v = {1'b0, seed[30:0]};
        wb(1'b1, `HRC_PV_SET, v);
        wb(1'b1, `HRC_CMD, 32'h8);
        rdc(`HRC_PV_BASE + 8'h1, v >> 16);
        step(4'h1, 4'h0, 3);
        rdc(`HRC_PV_BASE, {16'h0, v[15:0]});
        v = v + 32'h3;
        wb(1'b1, `HRC_CMD, 32'h2);
        rdc(`HRC_PV_BASE, {16'h0, v[15:0]});
        wb(1'b1, `HRC_PV_SET, lo + 1);
        wb(1'b1, `HRC_CMD, 32'h48);
        rdc(`HRC_STATUS0, st(lo));
        op_start <= 1'b1;
        @(posedge clk_sys);
        op_start <= 1'b0;
        rdc(`HRC_PV_BASE, 32'h0);
        rdc(`HRC_STATUS0, 32'h0000_0100);
        seed = xs(seed);
        v = {24'h0, seed[7:0]} + 32'h10;
        wb(1'b1, `HRC_CTRL, 32'h3);
        wb(1'b1, `HRC_PV_SET, v);
        wb(1'b1, `HRC_CMD, 32'h18);
        step(4'h1, 4'h0, 1);
        wb(1'b1, `HRC_CMD, 32'h4);
        rdc(`HRC_PV_BASE, 32'h0);
        step(4'h0, 4'h1, 1);
        wb(1'b1, `HRC_CMD, 32'h2);
        rdc(`HRC_PV_BASE, v);
        finish_test();
    end
endmodule
